// ---- hw/pss_strap_loader.sv ----
// Port 2 soft-strap loader with APB access to the dependent PHY and flow control bits
// Function
// - Negotiation strap sets negotiation enable default
// - Negotiation strap also shapes rate, duplex, advert, mode
// - Rate strap sets rate bit, advert, mode
// - Duplex strap sets duplex, 10FD advert, mode
// - Backpressure strap sets backpressure enable default
`timescale 1ns/1ps
module pss_strap_loader
   import pss_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic port2_negotiation_pin,
   input wire logic port2_rate_pin,
   input wire logic port2_duplex_pin,
   input wire logic port2_backpressure_default_pin,
   output logic negotiation_enable_bit,
   output logic rate_select_low_bit,
   output logic duplex_mode_bit,
   output logic [1:0] advert_10_bits,
   output logic [2:0] phy_mode,
   output logic port2_backpressure_bit
);
   logic [3:0] strap_sync;
   logic load;
   logic done;
   wire s_neg = strap_sync[0];
   wire s_rate = strap_sync[1];
   wire s_dup = strap_sync[2];
   wire s_bp = strap_sync[3];

   pss_strap_capture u_cap (
      .pclk(pclk),
      .presetn(presetn),
      .strap_pin({port2_backpressure_default_pin, port2_duplex_pin, port2_rate_pin,
                  port2_negotiation_pin}),
      .strap_sync(strap_sync),
      .load(load),
      .done(done)
   );

   // Strap-derived defaults; negotiation forces rate, duplex, 10HD advert and auto mode, while 10FD advert follows the duplex strap
   wire ld_neg = s_neg;
   wire ld_rate = s_neg | s_rate;
   wire ld_dup = s_neg | s_dup;
   wire ld_10hd = s_neg | ~s_rate;
   wire ld_10fd = (s_neg | ~s_rate) & s_dup;
   wire [2:0] ld_mode = s_neg ? PSS_MODE_AUTO : {1'b0, s_rate, s_dup};
   wire ld_bp = s_bp;

   // Bus decode; the bus stalls until the straps have loaded
   wire access = psel & penable & pready;
   wire wr = access & pwrite;
   wire hit_basic = (paddr == PSS_OFS_BASIC);
   wire hit_adv = (paddr == PSS_OFS_ADVERT);
   wire hit_mode = (paddr == PSS_OFS_MODE);
   wire hit_flow = (paddr == PSS_OFS_FLOW);
   wire hit_strap = (paddr == PSS_OFS_STRAP);
   wire mapped = hit_basic | hit_adv | hit_mode | hit_flow | hit_strap;
   wire wr_basic = wr & hit_basic;
   wire wr_adv = wr & hit_adv;
   wire wr_mode = wr & hit_mode;
   wire wr_flow = wr & hit_flow;

   // Ready also waits out the load pulse, so a write can never collide with the load
   assign pready = done & ~load;
   assign pslverr = psel & penable & ~mapped;

   pss_field #(.W(3), .RST({PSS_RST_RATE, PSS_RST_NEG, PSS_RST_DUPLEX})) u_basic (
      .pclk(pclk),
      .presetn(presetn),
      .load(load),
      .load_val({ld_rate, ld_neg, ld_dup}),
      .wr(wr_basic),
      .wr_val({pwdata[PSS_BIT_RATE_LOW], pwdata[PSS_BIT_NEG_EN], pwdata[PSS_BIT_DUPLEX]}),
      .q({rate_select_low_bit, negotiation_enable_bit, duplex_mode_bit})
   );

   pss_field #(.W(2), .RST(2'h3)) u_adv (
      .pclk(pclk),
      .presetn(presetn),
      .load(load),
      .load_val({ld_10fd, ld_10hd}),
      .wr(wr_adv),
      .wr_val({pwdata[PSS_BIT_ADV_10FD], pwdata[PSS_BIT_ADV_10HD]}),
      .q(advert_10_bits)
   );

   pss_field #(.W(3), .RST(PSS_MODE_AUTO)) u_mode (
      .pclk(pclk),
      .presetn(presetn),
      .load(load),
      .load_val(ld_mode),
      .wr(wr_mode),
      .wr_val(pwdata[PSS_MODE_LSB+2:PSS_MODE_LSB]),
      .q(phy_mode)
   );

   pss_field #(.W(1), .RST(PSS_RST_BP)) u_flow (
      .pclk(pclk),
      .presetn(presetn),
      .load(load),
      .load_val(ld_bp),
      .wr(wr_flow),
      .wr_val(pwdata[PSS_BIT_BP]),
      .q(port2_backpressure_bit)
   );

   // Read mux; unused bits read as zero
   pss_word_t rd_basic;
   pss_word_t rd_adv;
   pss_word_t rd_mode;
   pss_word_t rd_flow;
   pss_word_t rd_mux;
   always_comb
   begin
      rd_basic = '0;
      rd_basic[PSS_BIT_DUPLEX] = duplex_mode_bit;
      rd_basic[PSS_BIT_NEG_EN] = negotiation_enable_bit;
      rd_basic[PSS_BIT_RATE_LOW] = rate_select_low_bit;
      rd_adv = '0;
      rd_adv[PSS_BIT_ADV_10HD] = advert_10_bits[0];
      rd_adv[PSS_BIT_ADV_10FD] = advert_10_bits[1];
      rd_mode = '0;
      rd_mode[PSS_MODE_LSB+2:PSS_MODE_LSB] = phy_mode;
      rd_flow = '0;
      rd_flow[PSS_BIT_BP] = port2_backpressure_bit;
      rd_mux = '0;
      if (hit_basic)
         rd_mux = rd_basic;
      else if (hit_adv)
         rd_mux = rd_adv;
      else if (hit_mode)
         rd_mux = rd_mode;
      else if (hit_flow)
         rd_mux = rd_flow;
      else if (hit_strap)
         rd_mux = {28'h0, strap_sync};
   end

   // Captured every selected cycle so the access phase sees it from a flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0;
      else if (psel)
         prdata <= rd_mux;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_neg_load;
      load |=> negotiation_enable_bit == $past(s_neg);
   endproperty
   a_neg_load: assert property (p_neg_load)
      else $error("negotiation enable not loaded from strap");

   property p_neg_forces;
      load && s_neg |=> phy_mode == 3'h7 && rate_select_low_bit && duplex_mode_bit
         && advert_10_bits[0];
   endproperty
   a_neg_forces: assert property (p_neg_forces)
      else $error("negotiation strap did not force defaults");

   property p_rate_load;
      load && !s_neg |=> rate_select_low_bit == $past(s_rate)
         && advert_10_bits[0] == !$past(s_rate) && phy_mode[1] == $past(s_rate);
   endproperty
   a_rate_load: assert property (p_rate_load)
      else $error("rate strap defaults wrong");

   property p_dup_load;
      load && !s_neg |=> duplex_mode_bit == $past(s_dup) && phy_mode[0] == $past(s_dup)
         && advert_10_bits[1] == ($past(s_dup) && !$past(s_rate));
   endproperty
   a_dup_load: assert property (p_dup_load)
      else $error("duplex strap defaults wrong");

   property p_bp_load;
      load |=> port2_backpressure_bit == $past(s_bp);
   endproperty
   a_bp_load: assert property (p_bp_load)
      else $error("backpressure default not loaded from strap");

   property p_load_once;
      done && !load |=> !load;
   endproperty
   a_load_once: assert property (p_load_once)
      else $error("strap reloaded after init");

   property p_sticky;
      done && !load && !wr_flow |=> $stable(port2_backpressure_bit);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("backpressure bit changed without a write");

   property p_write_takes;
      wr_basic |=> negotiation_enable_bit == $past(pwdata[PSS_BIT_NEG_EN]);
   endproperty
   a_write_takes: assert property (p_write_takes)
      else $error("software write to control not kept");

   // Bus side: ready gating, write capture, hold without writes and readback, plus advert and mode strap load checks
   property p_ready_init;
      !done |-> !pready;
   endproperty
   a_ready_init: assert property (p_ready_init)
      else $error("ready high before straps loaded");

   property p_ready_load;
      load |-> !pready;
   endproperty
   a_ready_load: assert property (p_ready_load)
      else $error("ready high during strap load");

   property p_ready_stays;
      pready |=> pready;
   endproperty
   a_ready_stays: assert property (p_ready_stays)
      else $error("ready dropped after init");

   property p_adv_neg;
      load && s_neg |=> advert_10_bits[1] == $past(s_dup);
   endproperty
   a_adv_neg: assert property (p_adv_neg)
      else $error("full duplex advert not taken from duplex strap");

   property p_mode_plain;
      load && !s_neg |=> !phy_mode[2];
   endproperty
   a_mode_plain: assert property (p_mode_plain)
      else $error("mode top bit set without negotiation strap");

   property p_write_adv;
      wr_adv |=> advert_10_bits == $past({pwdata[PSS_BIT_ADV_10FD], pwdata[PSS_BIT_ADV_10HD]});
   endproperty
   a_write_adv: assert property (p_write_adv)
      else $error("software write to advert not kept");

   property p_write_mode;
      wr_mode |=> phy_mode == $past(pwdata[PSS_MODE_LSB+2:PSS_MODE_LSB]);
   endproperty
   a_write_mode: assert property (p_write_mode)
      else $error("software write to mode not kept");

   property p_write_flow;
      wr_flow |=> port2_backpressure_bit == $past(pwdata[PSS_BIT_BP]);
   endproperty
   a_write_flow: assert property (p_write_flow)
      else $error("software write to flow control not kept");

   property p_write_rest;
      wr_basic |=> rate_select_low_bit == $past(pwdata[PSS_BIT_RATE_LOW])
         && duplex_mode_bit == $past(pwdata[PSS_BIT_DUPLEX]);
   endproperty
   a_write_rest: assert property (p_write_rest)
      else $error("software write to rate or duplex not kept");

   property p_sticky_basic;
      done && !load && !wr_basic |=> $stable({rate_select_low_bit, negotiation_enable_bit,
         duplex_mode_bit});
   endproperty
   a_sticky_basic: assert property (p_sticky_basic)
      else $error("control bits changed without a write");

   property p_sticky_adv;
      done && !load && !wr_adv |=> $stable(advert_10_bits);
   endproperty
   a_sticky_adv: assert property (p_sticky_adv)
      else $error("advert bits changed without a write");

   property p_sticky_mode;
      done && !load && !wr_mode |=> $stable(phy_mode);
   endproperty
   a_sticky_mode: assert property (p_sticky_mode)
      else $error("mode field changed without a write");

   property p_basic_read;
      psel && hit_basic |=> prdata[PSS_BIT_NEG_EN] == $past(negotiation_enable_bit);
   endproperty
   a_basic_read: assert property (p_basic_read)
      else $error("negotiation enable read back wrong");

   property p_flow_read;
      psel && hit_flow |=> prdata[PSS_BIT_BP] == $past(port2_backpressure_bit);
   endproperty
   a_flow_read: assert property (p_flow_read)
      else $error("backpressure bit read back wrong");

   property p_mode_read;
      psel && hit_mode |=> prdata[PSS_MODE_LSB+2:PSS_MODE_LSB] == $past(phy_mode);
   endproperty
   a_mode_read: assert property (p_mode_read)
      else $error("mode field read back wrong");
endmodule : pss_strap_loader

// ---- hw/pss_pkg.sv ----
// Package with register map, field positions and strap defaults for the port 2 strap loader
package pss_pkg;
   localparam logic [7:0] PSS_OFS_BASIC = 8'h00;
   localparam logic [7:0] PSS_OFS_ADVERT = 8'h04;
   localparam logic [7:0] PSS_OFS_MODE = 8'h08;
   localparam logic [7:0] PSS_OFS_FLOW = 8'h0c;
   localparam logic [7:0] PSS_OFS_STRAP = 8'h10;
   localparam int PSS_BIT_DUPLEX = 8;
   localparam int PSS_BIT_NEG_EN = 12;
   localparam int PSS_BIT_RATE_LOW = 13;
   localparam int PSS_BIT_ADV_10HD = 5;
   localparam int PSS_BIT_ADV_10FD = 6;
   localparam int PSS_MODE_LSB = 5;
   localparam int PSS_BIT_BP = 0;
   localparam logic PSS_RST_NEG = 1'b1;
   localparam logic PSS_RST_RATE = 1'b1;
   localparam logic PSS_RST_DUPLEX = 1'b1;
   localparam logic PSS_RST_BP = 1'b1;
   localparam logic [2:0] PSS_MODE_AUTO = 3'h7;
   localparam logic [1:0] PSS_SETTLE_CYCLES = 2'h3;
   typedef logic [31:0] pss_word_t;
endpackage : pss_pkg

// ---- hw/pss_strap_capture.sv ----
// Strap pin synchroniser and one-shot load pulse after reset release
`timescale 1ns/1ps
module pss_strap_capture
   import pss_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] strap_pin,
   output logic [3:0] strap_sync,
   output logic load,
   output logic done
);
   logic [3:0] meta;
   logic [1:0] settle;
   // Pins reset to their documented defaults so an early read is sane
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta <= {PSS_RST_BP, PSS_RST_DUPLEX, PSS_RST_RATE, PSS_RST_NEG};
         strap_sync <= {PSS_RST_BP, PSS_RST_DUPLEX, PSS_RST_RATE, PSS_RST_NEG};
      end
      else
      begin
         meta <= strap_pin;
         strap_sync <= meta;
      end
   end
   // Wait until the second stage holds a real pin sample, then load once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         settle <= 2'h0;
         load <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         load <= 1'b0;
         if (!done && settle != PSS_SETTLE_CYCLES)
            settle <= settle + 2'h1;
         if (!done && settle == PSS_SETTLE_CYCLES)
         begin
            load <= 1'b1;
            done <= 1'b1;
         end
      end
   end
endmodule : pss_strap_capture

// ---- hw/pss_field.sv ----
// Writable register field with a constant reset and a strap-derived load value
`timescale 1ns/1ps
module pss_field #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic wr,
   input wire logic [W-1:0] wr_val,
   output logic [W-1:0] q
);
   // Load only happens once, before the bus is ready, so it never fights a write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= RST;
      else if (load)
         q <= load_val;
      else if (wr)
         q <= wr_val;
   end
endmodule : pss_field

// ---- testbench/pss_strap_loader_test.sv ----
// Self-checking bench for the port 2 strap loader
`timescale 1ns/1ps
module pss_strap_loader_test;
   import pss_pkg::*;
   typedef struct packed {logic [3:0] pins; logic [8:0] exp;} pss_row_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   pss_word_t pwdata = '0;
   pss_word_t prdata;
   pss_word_t rd;
   logic pready;
   logic pslverr;
   logic err;
   logic [3:0] pins = 4'hf;
   // Loaded bits {neg,rate,dup,adv[1:0],mode[2:0],bp}
   wire [8:0] outs;
   int error_cnt = 0;
   int checked = 0;
   // Pins are {bp,dup,rate,neg}
   pss_row_s rows [6] = '{'{4'hf, 9'h1ff}, '{4'h0, 9'h010}, '{4'he, 9'h0c7},
      '{4'h4, 9'h072}, '{4'ha, 9'h085}, '{4'h1, 9'h1de}};

   pss_strap_loader i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port2_negotiation_pin(pins[0]), .port2_rate_pin(pins[1]),
      .port2_duplex_pin(pins[2]), .port2_backpressure_default_pin(pins[3]),
      .negotiation_enable_bit(outs[8]), .rate_select_low_bit(outs[7]),
      .duplex_mode_bit(outs[6]), .advert_10_bits(outs[5:4]), .phy_mode(outs[3:1]),
      .port2_backpressure_bit(outs[0]));

   initial
   begin
      forever #4 pclk = ~pclk;
   end

   task automatic cmp_word(input pss_word_t got, input pss_word_t exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_outs(input logic [8:0] exp);
      checked++;
      if (outs !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t bits %h expected %h", $time, outs, exp);
      end
   endtask : cmp_outs

   // Master never assumes a latency; the wait ends on ready or at the 50-cycle limit
   task automatic apb(input logic wr, input logic [7:0] a, input pss_word_t d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      if (n >= 50)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t no ready", $time);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic do_reset(input logic [3:0] p);
      int n;
      presetn <= 1'b0;
      pins <= p;
      repeat (20) @(posedge pclk);
      cmp_outs(9'h1ff);
      cmp_word({31'h0, pready}, 32'h0);
      presetn <= 1'b1;
      n = 0;
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      // Ready is first seen high one edge after the load pulse has gone
      cmp_word(pss_word_t'(n), 32'(PSS_SETTLE_CYCLES) + 32'h3);
      #1;
   endtask : do_reset

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   initial
   begin
      foreach (rows[i])
      begin
         do_reset(rows[i].pins);
         cmp_outs(rows[i].exp);
         apb(1'b0, PSS_OFS_BASIC, '0);
         cmp_word(rd, {18'h0, rows[i].exp[7], rows[i].exp[8], 3'h0, rows[i].exp[6], 8'h0});
         apb(1'b0, PSS_OFS_MODE, '0);
         cmp_word(rd, {24'h0, rows[i].exp[3:1], 5'h0});
         apb(1'b0, PSS_OFS_ADVERT, '0);
         cmp_word(rd, {25'h0, rows[i].exp[5:4], 5'h0});
         apb(1'b0, PSS_OFS_FLOW, '0);
         cmp_word(rd, {31'h0, rows[i].exp[0]});
         cmp_word({31'h0, err}, 32'h0);
         apb(1'b0, PSS_OFS_STRAP, '0);
         cmp_word(rd, {28'h0, rows[i].pins});
         $display("strap row %0d done", i);
      end
      // Software values must survive later pin changes
      apb(1'b1, PSS_OFS_BASIC, '0);
      apb(1'b1, PSS_OFS_ADVERT, '0);
      apb(1'b1, PSS_OFS_MODE, 32'h000000a0);
      apb(1'b1, PSS_OFS_FLOW, 32'hffffffff);
      apb(1'b0, PSS_OFS_FLOW, '0);
      cmp_word(rd, 32'h00000001);
      apb(1'b1, PSS_OFS_FLOW, '0);
      pins <= 4'h5;
      repeat (6) @(posedge pclk);
      cmp_outs(9'h00a);
      apb(1'b0, PSS_OFS_STRAP, '0);
      cmp_word(rd, 32'h00000005);
      $display("write persistence done");
      // Unmapped place: error, write ignored, reads zero
      apb(1'b1, 8'h20, 32'hffffffff);
      cmp_word({31'h0, err}, 32'h1);
      apb(1'b0, 8'h20, '0);
      cmp_word({31'h0, err}, 32'h1);
      cmp_word(rd, 32'h0);
      cmp_outs(9'h00a);
      $display("unmapped access done");
      // A second reset reloads from the pins now present
      do_reset(4'h5);
      cmp_outs(9'h1fe);
      $display("second reset done");
      // A write issued during init waits for ready and is not undone by the load
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, PSS_OFS_FLOW, 32'h00000001);
      @(posedge pclk);
      cmp_outs(9'h1ff);
      $display("write during init done");
      complete_run();
   end

   initial
   begin
      #(8 * 5000);
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      complete_run();
   end
endmodule : pss_strap_loader_test
